// ---- gwgw_pkg.sv ----
package gwgw_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PIX_W = 18;
  localparam int ADR_W = 4;
  localparam int CRD_W = 8;
  localparam int IDX_W = 16;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WIN_X = 4'h1;
  localparam logic [3:0] REG_WIN_Y = 4'h2;
  localparam logic [3:0] REG_AC = 4'h3;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_CMP = 4'h5;
  localparam logic [3:0] REG_PIXEL = 4'h6;
  localparam logic [3:0] REG_RDL = 4'h7;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int CTL_INC = 0;
  localparam int CTL_AXIS = 1;
  localparam int CTL_OP_LO = 2;
  localparam int CTL_REV = 5;
  localparam int CTL_SWAP = 6;
  localparam int CTL_BUS18 = 7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] X_START_RST = 8'h00;
  localparam logic [7:0] X_END_RST = 8'hAF;
  localparam logic [7:0] Y_START_RST = 8'h00;
  localparam logic [7:0] Y_END_RST = 8'hDB;
  localparam logic [17:0] MASK_RST = 18'h00000;
  localparam logic [17:0] CMP_RST = 18'h00000;
  localparam logic [15:0] AC_RST = 16'h0000;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [2:0] {
    OP_REPLACE = 3'h0,
    OP_OR = 3'h1,
    OP_AND = 3'h2,
    OP_XOR = 3'h3,
    OP_OLD_EQ = 3'h4,
    OP_OLD_NE = 3'h5,
    OP_NEW_EQ = 3'h6,
    OP_NEW_NE = 3'h7
  } gwgw_op_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [17:0] wdata;
    logic wr;
    logic rd;
  } gwgw_bus_t;

  typedef struct packed {
    logic req;
    logic [7:0] row;
    logic [7:0] col;
  } gwgw_scan_t;

endpackage

// ---- gwgw_engine.sv ----
`timescale 1ns/1ns
// How it works
// - in reset panel outputs sit at ground, oscillator flag stays running
// - each pixel is one 18-bit word of the pixel memory
// - pixel memory reachable for read and write from the host port
// - address high byte is row, low byte is column
// - reversed column order mirrors columns toward the display scan
// - host writes pixels consecutively inside the programmed rectangle
// - scan_axis_select picks horizontal or vertical counter advance
// - operation_select decodes replace, logic and four conditional write kinds
// - 16-bit words expand to 18 bits, 18-bit mode stores as is
// - mask bit 0 writes the new bit, mask bit 1 keeps stored bit
// - plain replacement honours the bit mask
// - horizontal step plus or minus one, edge jumps one row down, from the bottom row back to the top row
// - logic modes combine host word with stored pixel and write back
// - conditional modes write only when compare condition holds
// - vertical step one row, bottom edge jumps to top next column
// - stored pixel is caught in the read latch on the same strobe
module gwgw_engine #(
  parameter int MEM_COLS = 176,
  parameter int MEM_ROWS = 220
) (
  input wire logic core_clk_i, // core clock
  input wire logic nrst_i, // sync reset, low
  input wire gwgw_pkg::gwgw_bus_t bus_i, // register port
  input wire gwgw_pkg::gwgw_scan_t scan_i, // display fetch
  output logic [17:0] rdata_o, // read data
  output logic [17:0] disp_pixel_o, // source data
  output logic gate_drive_o, // gate line active
  output logic common_electrode_out_o, // common polarity
  output logic frame_marker_out_o, // frame start
  output logic osc_run_o // oscillator running
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (MEM_COLS < 2 || MEM_COLS > 256 || MEM_ROWS < 2 || MEM_ROWS > 256 ||
      MEM_COLS * MEM_ROWS > 65536) begin : g_bad
    $error("gwgw_engine: memory geometry out of range");
  end

  localparam int DEPTH = MEM_COLS * MEM_ROWS;
  localparam logic [7:0] COL_LAST = 8'(MEM_COLS - 1);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] idx_of(input logic [7:0] row, input logic [7:0] col);
    idx_of = 16'(row * MEM_COLS) + 16'(col);
  endfunction

  function automatic logic [17:0] swap_rb(input logic [17:0] p, input logic sw);
    swap_rb = sw ? {p[5:0], p[11:6], p[17:12]} : p;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] x_start_q;
  logic [7:0] x_end_q;
  logic [7:0] y_start_q;
  logic [7:0] y_end_q;
  logic [15:0] ac_q;
  logic [15:0] ac_d;
  logic [17:0] mask_q;
  logic [17:0] cmp_q;
  logic [17:0] rdl_q;
  logic [17:0] mem [DEPTH];

  logic inc;
  logic axis_v;
  gwgw_pkg::gwgw_op_t op;
  logic [7:0] col;
  logic [7:0] row;
  logic [15:0] cur_idx;
  logic [17:0] stored;
  logic [17:0] incoming;
  logic [17:0] result;
  logic [17:0] merged;
  logic go;
  logic pix_wr;

  assign inc = ctrl_q[gwgw_pkg::CTL_INC];
  assign axis_v = ctrl_q[gwgw_pkg::CTL_AXIS];
  assign op = gwgw_pkg::gwgw_op_t'(ctrl_q[gwgw_pkg::CTL_OP_LO +: 3]);
  assign row = ac_q[15:8];
  assign col = ac_q[7:0];
  assign cur_idx = idx_of(row, col);
  assign stored = mem[cur_idx];
  assign pix_wr = bus_i.wr && (bus_i.addr == gwgw_pkg::REG_PIXEL);

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= gwgw_pkg::CTRL_RST;
      x_start_q <= gwgw_pkg::X_START_RST;
      x_end_q <= gwgw_pkg::X_END_RST;
      y_start_q <= gwgw_pkg::Y_START_RST;
      y_end_q <= gwgw_pkg::Y_END_RST;
      mask_q <= gwgw_pkg::MASK_RST;
      cmp_q <= gwgw_pkg::CMP_RST;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        gwgw_pkg::REG_CTRL: ctrl_q <= bus_i.wdata[7:0];
        gwgw_pkg::REG_WIN_X: begin
          x_start_q <= bus_i.wdata[7:0];
          x_end_q <= bus_i.wdata[15:8];
        end
        gwgw_pkg::REG_WIN_Y: begin
          y_start_q <= bus_i.wdata[7:0];
          y_end_q <= bus_i.wdata[15:8];
        end
        gwgw_pkg::REG_MASK: mask_q <= bus_i.wdata;
        gwgw_pkg::REG_CMP: cmp_q <= bus_i.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // pixel path
  // ****************************************
  always_comb begin
    if (ctrl_q[gwgw_pkg::CTL_BUS18]) begin
      incoming = swap_rb(bus_i.wdata, ctrl_q[gwgw_pkg::CTL_SWAP]);
    end else begin
      incoming = swap_rb({bus_i.wdata[15:11], bus_i.wdata[15], bus_i.wdata[10:5],
                          bus_i.wdata[4:0], bus_i.wdata[4]}, ctrl_q[gwgw_pkg::CTL_SWAP]);
    end
  end

  always_comb begin
    result = incoming;
    go = 1'b1;
    case (op)
      gwgw_pkg::OP_REPLACE: go = 1'b1;
      gwgw_pkg::OP_OR: result = incoming | stored;
      gwgw_pkg::OP_AND: result = incoming & stored;
      gwgw_pkg::OP_XOR: result = incoming ^ stored;
      gwgw_pkg::OP_OLD_EQ: go = (stored == cmp_q);
      gwgw_pkg::OP_OLD_NE: go = (stored != cmp_q);
      gwgw_pkg::OP_NEW_EQ: go = (incoming == cmp_q);
      gwgw_pkg::OP_NEW_NE: go = (incoming != cmp_q);
      default: go = 1'b0;
    endcase
  end

  // per-bit mask, also in replace mode
  assign merged = (result & ~mask_q) | (stored & mask_q);

  // 18-bit words, not cleared by reset
  always_ff @(posedge core_clk_i) begin
    if (nrst_i && pix_wr && go) begin
      mem[cur_idx] <= merged;
    end
  end

  // read latch on the write strobe
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdl_q <= 18'h00000;
    end else if (pix_wr) begin
      rdl_q <= stored;
    end
  end

  // ****************************************
  // address counter
  // ****************************************
  // relies on a start point inside the window
  always_comb begin
    ac_d = ac_q;
    if (!axis_v) begin
      if (inc ? (col == x_end_q) : (col == x_start_q)) begin
        ac_d[7:0] = inc ? x_start_q : x_end_q;
        ac_d[15:8] = (row == y_end_q) ? y_start_q : row + 8'h01;
      end else begin
        ac_d[7:0] = inc ? col + 8'h01 : col - 8'h01;
      end
    end else begin
      if (row == y_end_q) begin
        ac_d[15:8] = y_start_q;
        if (inc) begin
          ac_d[7:0] = (col == x_end_q) ? x_start_q : col + 8'h01;
        end else begin
          ac_d[7:0] = (col == x_start_q) ? x_end_q : col - 8'h01;
        end
      end else begin
        ac_d[15:8] = row + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ac_q <= gwgw_pkg::AC_RST;
    end else if (bus_i.wr && bus_i.addr == gwgw_pkg::REG_AC) begin
      ac_q <= bus_i.wdata[15:0];
    end else if (pix_wr) begin
      ac_q <= ac_d;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // host read path
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 18'h00000;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        gwgw_pkg::REG_CTRL: rdata_o <= {10'h000, ctrl_q};
        gwgw_pkg::REG_WIN_X: rdata_o <= {2'h0, x_end_q, x_start_q};
        gwgw_pkg::REG_WIN_Y: rdata_o <= {2'h0, y_end_q, y_start_q};
        gwgw_pkg::REG_AC: rdata_o <= {2'h0, ac_q};
        gwgw_pkg::REG_MASK: rdata_o <= mask_q;
        gwgw_pkg::REG_CMP: rdata_o <= cmp_q;
        gwgw_pkg::REG_PIXEL: rdata_o <= stored;
        gwgw_pkg::REG_RDL: rdata_o <= rdl_q;
        default: rdata_o <= 18'h00000;
      endcase
    end else begin
      rdata_o <= 18'h00000;
    end
  end

  // ****************************************
  // display side
  // ****************************************
  logic [7:0] scan_col;

  assign scan_col = ctrl_q[gwgw_pkg::CTL_REV] ? COL_LAST - scan_i.col : scan_i.col;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      disp_pixel_o <= 18'h00000;
      gate_drive_o <= 1'b0;
      frame_marker_out_o <= 1'b0;
      common_electrode_out_o <= 1'b0;
      osc_run_o <= 1'b1;
    end else begin
      disp_pixel_o <= scan_i.req ? mem[idx_of(scan_i.row, scan_col)] : 18'h00000;
      gate_drive_o <= scan_i.req;
      frame_marker_out_o <= scan_i.req && scan_i.row == 8'h00 && scan_i.col == 8'h00;
      if (scan_i.req && scan_i.row == 8'h00 && scan_i.col == 8'h00) begin
        common_electrode_out_o <= !common_electrode_out_o;
      end
      osc_run_o <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic chk_wr_q;
  logic [15:0] chk_idx_q;
  logic [17:0] chk_old_q;
  logic [17:0] chk_new_q;
  logic [17:0] chk_mask_q;
  logic chk_go_q;
  gwgw_pkg::gwgw_op_t chk_op_q;

  always_ff @(posedge core_clk_i) begin
    chk_wr_q <= nrst_i && pix_wr;
    chk_idx_q <= cur_idx;
    chk_old_q <= stored;
    chk_new_q <= incoming;
    chk_mask_q <= mask_q;
    chk_go_q <= go;
    chk_op_q <= op;
  end

  logic in_win;
  assign in_win = col >= x_start_q && col <= x_end_q && row >= y_start_q && row <= y_end_q;

  reset_ground_a: assert property (@(posedge core_clk_i)
    !nrst_i |=> (disp_pixel_o == 18'h00000 && !frame_marker_out_o && !gate_drive_o &&
      !common_electrode_out_o && osc_run_o))
    else $error("outputs not grounded in reset");

  window_stay_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && in_win && !bus_i.rd |=> in_win)
    else $error("address left the window");

  horiz_step_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && !axis_v && inc && col != x_end_q |=> col == $past(col) + 8'h01)
    else $error("horizontal step wrong");

  vert_step_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && axis_v && row != y_end_q |=> row == $past(row) + 8'h01 && col == $past(col))
    else $error("vertical step wrong");

  mask_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    chk_wr_q |-> (mem[chk_idx_q] & chk_mask_q) == (chk_old_q & chk_mask_q))
    else $error("masked bit overwritten");

  latch_fetch_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    chk_wr_q |-> rdl_q == chk_old_q)
    else $error("read latch missed stored pixel");

  cond_skip_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    chk_wr_q && !chk_go_q |-> mem[chk_idx_q] == chk_old_q)
    else $error("conditional write not suppressed");

  or_write_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    chk_wr_q && chk_op_q == gwgw_pkg::OP_OR && chk_mask_q == 18'h00000 |->
      mem[chk_idx_q] == (chk_old_q | chk_new_q))
    else $error("OR result wrong");

  replace_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    chk_wr_q && chk_op_q == gwgw_pkg::OP_REPLACE |->
      mem[chk_idx_q] == ((chk_new_q & ~chk_mask_q) | (chk_old_q & chk_mask_q)))
    else $error("masked replace wrong");

  ac_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    bus_i.rd && bus_i.addr == gwgw_pkg::REG_AC |=> rdata_o == {2'h0, $past(ac_q)})
    else $error("counter read wrong");

  replace_seen_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && op == gwgw_pkg::OP_REPLACE);
  logic_seen_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && op == gwgw_pkg::OP_XOR);
  cond_skip_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && !go);
  row_wrap_c: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    pix_wr && !axis_v && inc && col == x_end_q && row == y_end_q);

endmodule

// ---- gwgw_host_model.sv ----
`timescale 1ns/1ns
// ****************************************
// host side of the register port
// ****************************************
module gwgw_host_model (
  input wire logic core_clk_i, // core clock
  input wire logic [17:0] rdata_i, // read data
  output gwgw_pkg::gwgw_bus_t bus_o // register port
);
  logic [7:0] wx0, wx1, wy0, wy1;

  initial begin
    bus_o = '0;
    wx0 = 8'h00;
    wx1 = 8'hAF;
    wy0 = 8'h00;
    wy1 = 8'hDB;
  end

  task automatic reg_wr(input logic [3:0] a, input logic [17:0] d);
    @(posedge core_clk_i);
    bus_o.addr <= a;
    bus_o.wdata <= d;
    bus_o.wr <= 1'b1;
    @(posedge core_clk_i);
    bus_o.wr <= 1'b0;
    bus_o.addr <= ~a;
    bus_o.wdata <= ~d;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [17:0] d);
    @(posedge core_clk_i);
    bus_o.addr <= a;
    bus_o.rd <= 1'b1;
    @(posedge core_clk_i);
    bus_o.rd <= 1'b0;
    bus_o.addr <= ~a;
    #1;
    d = rdata_i;
  endtask

  task automatic set_window(input logic [7:0] xs, xe, ys, ye);
    wx1 = (xe > 8'hAF) ? 8'hAF : xe;
    wx0 = (xs > wx1) ? wx1 : xs;
    wy1 = (ye > 8'hDB) ? 8'hDB : ye;
    wy0 = (ys > wy1) ? wy1 : ys;
    reg_wr(gwgw_pkg::REG_WIN_X, {2'h0, wx1, wx0});
    reg_wr(gwgw_pkg::REG_WIN_Y, {2'h0, wy1, wy0});
  endtask

  task automatic set_ac(input logic [7:0] r, c);
    r = (r < wy0) ? wy0 : (r > wy1) ? wy1 : r;
    c = (c < wx0) ? wx0 : (c > wx1) ? wx1 : c;
    reg_wr(gwgw_pkg::REG_AC, {2'h0, r, c});
  endtask
endmodule

// ---- pixel_memory_window_graphics_write_tb_top.sv ----
`timescale 1ns/1ns
module pixel_memory_window_graphics_write_tb_top;
  logic core_clk_i, nrst_i, gate, com, frm, osc, com0;
  gwgw_pkg::gwgw_bus_t bus;
  gwgw_pkg::gwgw_scan_t scan;
  logic [17:0] rdata, disp, v;
  logic [17:0] base [2];
  logic [17:0] hw [2];
  int errors, checks;

  gwgw_engine gwgw_engine_inst (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .bus_i(bus),
    .scan_i(scan),
    .rdata_o(rdata),
    .disp_pixel_o(disp),
    .gate_drive_o(gate),
    .common_electrode_out_o(com),
    .frame_marker_out_o(frm),
    .osc_run_o(osc)
  );

  gwgw_host_model gwgw_host_model_inst (
    .core_clk_i(core_clk_i),
    .rdata_i(rdata),
    .bus_o(bus)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [17:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    gwgw_host_model_inst.reg_wr(a, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [17:0] exp);
    logic [17:0] d;
    gwgw_host_model_inst.reg_rd(a, d);
    check(d, exp);
  endtask

  task automatic pix_at(input logic [15:0] ac, input logic [17:0] exp);
    wr(gwgw_pkg::REG_AC, {2'h0, ac});
    rd_chk(gwgw_pkg::REG_PIXEL, exp);
  endtask

  task automatic scan_chk(input logic [7:0] r, c, input logic [17:0] exp);
    logic org;
    org = (r == 8'h00) && (c == 8'h00);
    com0 = com;
    @(posedge core_clk_i);
    scan <= {1'b1, r, c};
    @(posedge core_clk_i);
    scan <= {1'b0, ~r, ~c};
    #1;
    check(disp, exp);
    check({17'h0, gate}, 18'h00001);
    check({17'h0, frm}, {17'h0, org});
    check({17'h0, com}, {17'h0, com0 ^ org});
  endtask

  function automatic logic [17:0] ctl(input logic [2:0] op, input logic ax, inc, rev, b18);
    return {10'h000, b18, 1'b0, rev, op, ax, inc};
  endfunction

  function automatic logic [17:0] op_res(input logic [2:0] op, input logic [17:0] o, n, cp);
    case (op)
      3'h1: return o | n;
      3'h2: return o & n;
      3'h3: return o ^ n;
      3'h4: return (o == cp) ? n : o;
      3'h5: return (o != cp) ? n : o;
      3'h6: return (n == cp) ? n : o;
      3'h7: return (n != cp) ? n : o;
      default: return n;
    endcase
  endfunction

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  initial begin
    #(40 * 20000);
    errors++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    nrst_i = 1'b0;
    scan = '0;
    errors = 0;
    checks = 0;
    base = '{18'h12860, 18'h0AAAA};
    hw = '{18'h0F0F0, 18'h12860};
    repeat (5) @(posedge core_clk_i);
    #1;
    check(disp, 18'h00000);
    check({15'h0, gate, com, frm}, 18'h00000);
    check({17'h0, osc}, 18'h00001);
    @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd_chk(gwgw_pkg::REG_CTRL, 18'h00001);
    rd_chk(gwgw_pkg::REG_WIN_X, 18'h0AF00);
    rd_chk(gwgw_pkg::REG_WIN_Y, 18'h0DB00);
    rd_chk(4'h9, 18'h00000);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    wr(gwgw_pkg::REG_AC, 18'h000AF);
    wr(gwgw_pkg::REG_PIXEL, 18'h2AAAA);
    wr(gwgw_pkg::REG_AC, 18'h00000);
    wr(gwgw_pkg::REG_PIXEL, 18'h3C3C3);
    wr(gwgw_pkg::REG_AC, 18'h00100);
    wr(gwgw_pkg::REG_PIXEL, 18'h15555);
    rd_chk(gwgw_pkg::REG_AC, 18'h00101);
    pix_at(16'h0100, 18'h15555);
    scan_chk(8'h01, 8'h00, 18'h15555);
    scan_chk(8'h00, 8'h00, 18'h3C3C3);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b1, 1'b1));
    scan_chk(8'h00, 8'h00, 18'h2AAAA);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    gwgw_host_model_inst.set_window(8'h10, 8'h12, 8'h20, 8'h21);
    gwgw_host_model_inst.set_ac(8'h20, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(gwgw_pkg::REG_PIXEL, 18'h00100 + 18'(i));
    end
    rd_chk(gwgw_pkg::REG_AC, 18'h02111);
    wr(gwgw_pkg::REG_PIXEL, 18'h00104);
    wr(gwgw_pkg::REG_PIXEL, 18'h00105);
    rd_chk(gwgw_pkg::REG_AC, 18'h02010);
    pix_at(16'h2012, 18'h00102);
    pix_at(16'h2110, 18'h00103);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    gwgw_host_model_inst.set_ac(8'h20, 8'h10);
    wr(gwgw_pkg::REG_PIXEL, 18'h00001);
    rd_chk(gwgw_pkg::REG_AC, 18'h02112);
    gwgw_host_model_inst.set_ac(8'h20, 8'h12);
    wr(gwgw_pkg::REG_PIXEL, 18'h00005);
    rd_chk(gwgw_pkg::REG_AC, 18'h02011);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b1, 1'b1, 1'b0, 1'b1));
    gwgw_host_model_inst.set_ac(8'h20, 8'h12);
    wr(gwgw_pkg::REG_PIXEL, 18'h00002);
    rd_chk(gwgw_pkg::REG_AC, 18'h02112);
    gwgw_host_model_inst.set_ac(8'h21, 8'h10);
    wr(gwgw_pkg::REG_PIXEL, 18'h00003);
    rd_chk(gwgw_pkg::REG_AC, 18'h02011);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b1, 1'b0, 1'b0, 1'b1));
    gwgw_host_model_inst.set_ac(8'h21, 8'h11);
    wr(gwgw_pkg::REG_PIXEL, 18'h00004);
    rd_chk(gwgw_pkg::REG_AC, 18'h02010);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    gwgw_host_model_inst.set_ac(8'h20, 8'h10);
    wr(gwgw_pkg::REG_PIXEL, 18'h12345);
    wr(gwgw_pkg::REG_MASK, 18'h00FFF);
    gwgw_host_model_inst.set_ac(8'h20, 8'h10);
    wr(gwgw_pkg::REG_PIXEL, 18'h3FFFF);
    pix_at(16'h2010, 18'h3F345);
    wr(gwgw_pkg::REG_MASK, 18'h00000);
    wr(gwgw_pkg::REG_CMP, 18'h12860);
    for (int k = 0; k < 2; k++) begin
      for (int op = 1; op < 8; op++) begin
        wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1));
        gwgw_host_model_inst.set_ac(8'h20, 8'h11);
        wr(gwgw_pkg::REG_PIXEL, base[k]);
        wr(gwgw_pkg::REG_CTRL, ctl(3'(op), 1'b0, 1'b1, 1'b0, 1'b1));
        gwgw_host_model_inst.set_ac(8'h20, 8'h11);
        wr(gwgw_pkg::REG_PIXEL, hw[k]);
        v = op_res(3'(op), base[k], hw[k], 18'h12860);
        pix_at(16'h2011, v);
        rd_chk(gwgw_pkg::REG_RDL, base[k]);
      end
    end
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    gwgw_host_model_inst.set_ac(8'h20, 8'h12);
    wr(gwgw_pkg::REG_PIXEL, 18'h08410);
    pix_at(16'h2012, 18'h21821);
    wr(gwgw_pkg::REG_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1) | 18'h00040);
    gwgw_host_model_inst.set_ac(8'h20, 8'h10);
    wr(gwgw_pkg::REG_PIXEL, 18'h3F001);
    pix_at(16'h2010, 18'h0103F);
    give_verdict();
  end
endmodule
